// ==== pkg/pal_pkg.sv ====
// Package for the PCI address/data lane ends: constants, commands, states
`default_nettype none
package pal_pkg;
  localparam int AD_W = 32;
  localparam int BE_W = 4;
  localparam logic [1:0] AD_LINEAR_BURST = 2'h0;
  localparam int BUF_DEPTH = 2;
  localparam logic [AD_W-1:0] AD_RESET = 32'h0000_0000;
  localparam logic [BE_W-1:0] BE_RESET = 4'h0;
  localparam logic [BE_W-1:0] BE_ALL = 4'h0;
  localparam int BAR_LSB = 8;
  localparam logic [AD_W-1:0] BAR_DEFAULT = 32'h0001_0000;
  // Published bus command codes
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  typedef enum logic [2:0] {
    PAL_IDLE, PAL_ADDR, PAL_DATA, PAL_TURN, PAL_PARK
  } pal_state_t;
  // Byte reversal for FIFO data when swapping
  function automatic logic [AD_W-1:0] pal_swap(input logic [AD_W-1:0] d,
                                                input logic en);
    pal_swap = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction
  // Target claims only memory read and write
  function automatic logic pal_claimable(input logic [3:0] cmd);
    pal_claimable = (cmd == CMD_MEM_READ) || (cmd == CMD_MEM_WRITE);
  endfunction
endpackage
`default_nettype wire

// ==== pkg/pal_bus_if.sv ====
// Interface carrying the shared AD, C/BE, frame and ready lines
`timescale 1ns/100ps
`default_nettype none
interface pal_bus_if;
  import pal_pkg::*;
  logic [AD_W-1:0] dev_ad_o, hst_ad_o;
  logic dev_ad_oe, hst_ad_oe;
  logic [BE_W-1:0] dev_cbe_o, hst_cbe_o;
  logic dev_cbe_oe, hst_cbe_oe;
  logic dev_frame_n_o, hst_frame_n_o, dev_frame_oe, hst_frame_oe;
  logic dev_irdy_n_o, hst_irdy_n_o, dev_irdy_oe, hst_irdy_oe;
  logic dev_trdy_n_o, hst_trdy_n_o, dev_trdy_oe, hst_trdy_oe;
  logic dev_gnt_n, hst_gnt_n;
  // Resolved wire levels; undriven C/BE, frame and ready lines pull high, undriven AD reads AD_RESET
  logic [AD_W-1:0] ad;
  logic [BE_W-1:0] cbe;
  logic frame_n, irdy_n, trdy_n;
  assign ad = dev_ad_oe ? dev_ad_o : (hst_ad_oe ? hst_ad_o : AD_RESET);
  assign cbe = dev_cbe_oe ? dev_cbe_o : (hst_cbe_oe ? hst_cbe_o : 4'hF);
  assign frame_n = dev_frame_oe ? dev_frame_n_o : (hst_frame_oe ? hst_frame_n_o : 1'b1);
  assign irdy_n = dev_irdy_oe ? dev_irdy_n_o : (hst_irdy_oe ? hst_irdy_n_o : 1'b1);
  assign trdy_n = dev_trdy_oe ? dev_trdy_n_o : (hst_trdy_oe ? hst_trdy_n_o : 1'b1);
  modport dev (
    output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_frame_n_o, dev_frame_oe,
    output dev_irdy_n_o, dev_irdy_oe, dev_trdy_n_o, dev_trdy_oe,
    input ad, cbe, frame_n, irdy_n, trdy_n, dev_gnt_n
  );
  modport hst (
    output hst_ad_o, hst_ad_oe, hst_cbe_o, hst_cbe_oe, hst_frame_n_o, hst_frame_oe,
    output hst_irdy_n_o, hst_irdy_oe, hst_trdy_n_o, hst_trdy_oe,
    input ad, cbe, frame_n, irdy_n, trdy_n, hst_gnt_n
  );
endinterface
`default_nettype wire

// ==== rtl/pal_dev_end.sv ====
// Controller end: bus master for FIFO and plain words, memory target with buffer
`timescale 1ns/100ps
`default_nettype none
module pal_dev_end
  import pal_pkg::*;
#(
  parameter logic [AD_W-1:0] BAR = BAR_DEFAULT
) (
  input wire logic clk,
  input wire logic arst_n,
  pal_bus_if.dev bus,
  input wire logic byte_swap_enable,
  input wire logic mst_req_valid,
  output logic mst_req_ready,
  input wire logic mst_write,
  input wire logic [AD_W-1:0] mst_addr,
  input wire logic [AD_W-1:0] mst_wdata,
  input wire logic [BE_W-1:0] mst_be_n,
  input wire logic mst_fifo,
  output logic mst_rd_valid,
  output logic [AD_W-1:0] mst_rd_data,
  output logic slv_wr_valid,
  input wire logic slv_wr_ready,
  output logic [AD_W-1:0] slv_wr_data,
  output logic [BE_W-1:0] slv_wr_be_n,
  input wire logic [AD_W-1:0] slv_rd_data
);
  import pal_pkg::*;
  pal_state_t st_q, st_d;
  logic is_mst_q, write_q, fifo_q, hold_hi_q;
  logic [AD_W-1:0] ad_q, rd_q;
  logic [BE_W-1:0] be_q;
  logic slave_hit_q, slv_wr_q;
  logic [AD_W-1:0] buf_d_q [BUF_DEPTH];
  logic [BE_W-1:0] buf_b_q [BUF_DEPTH];
  logic wp_q, rp_q;
  logic [1:0] cnt_q;
  // Two-entry buffer flags; full stalls target ready
  wire buf_full = (cnt_q == 2'(BUF_DEPTH));
  wire buf_empty = (cnt_q == 2'h0);
  wire push = slave_hit_q && slv_wr_q && !bus.irdy_n && !bus.trdy_n;
  wire pop = !buf_empty && slv_wr_ready;
  // Address phase seen when frame falls while bus idle
  wire addr_phase = (st_q == PAL_IDLE) && !bus.frame_n;
  wire hit = addr_phase && !is_mst_q && pal_claimable(bus.cbe) &&
    (bus.ad[AD_W-1:BAR_LSB] == BAR[AD_W-1:BAR_LSB]);
  wire xfer = !bus.irdy_n && !bus.trdy_n;
  wire start = (st_q == PAL_IDLE) && bus.frame_n && !bus.dev_gnt_n && mst_req_valid;
  assign mst_req_ready = start;
  assign slv_wr_valid = !buf_empty;
  assign slv_wr_data = buf_d_q[rp_q];
  assign slv_wr_be_n = buf_b_q[rp_q];
  // State selection
  always_comb begin
    st_d = st_q;
    case (st_q)
      PAL_IDLE: begin
        if (start) st_d = PAL_ADDR;
        else if (hit) st_d = PAL_DATA;
      end
      PAL_ADDR: st_d = PAL_DATA;
      PAL_DATA: if (xfer) st_d = PAL_TURN;
      PAL_TURN: st_d = PAL_IDLE;
      default: st_d = PAL_IDLE;
    endcase
  end
  // Sequence and captured fields; all on rising edge
  // Only bus clock here, no network logic; state simply holds if it stops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= PAL_IDLE;
      is_mst_q <= 1'b0;
      write_q <= 1'b0;
      fifo_q <= 1'b0;
      ad_q <= AD_RESET;
      be_q <= BE_RESET;
      slave_hit_q <= 1'b0;
      slv_wr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (start) begin
        is_mst_q <= 1'b1;
        write_q <= mst_write;
        fifo_q <= mst_fifo;
        ad_q <= {mst_addr[AD_W-1:2], AD_LINEAR_BURST};
        be_q <= mst_be_n; // never swapped
      end else if (hit) begin
        slave_hit_q <= 1'b1;
        slv_wr_q <= bus.cbe[0];
      end
      if (st_q == PAL_ADDR && write_q)
        ad_q <= pal_swap(mst_wdata, byte_swap_enable && fifo_q);
      if (st_q == PAL_TURN) begin
        is_mst_q <= 1'b0;
        slave_hit_q <= 1'b0;
      end
    end
  end
  // Read capture: master data on completed data phase, target read data at address phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= AD_RESET;
      mst_rd_valid <= 1'b0;
      mst_rd_data <= AD_RESET;
    end else begin
      mst_rd_valid <= is_mst_q && !write_q && st_q == PAL_DATA && xfer;
      if (is_mst_q && !write_q && st_q == PAL_DATA && xfer)
        mst_rd_data <= pal_swap(bus.ad, byte_swap_enable && fifo_q);
      if (addr_phase)
        rd_q <= slv_rd_data;
    end
  end
  // Slave write buffer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        buf_d_q[wp_q] <= bus.ad;
        buf_b_q[wp_q] <= bus.cbe;
        wp_q <= ~wp_q;
      end
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
  // Sustained tri-state: one high clock in TURN before release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hold_hi_q <= 1'b0;
    else hold_hi_q <= (st_d == PAL_TURN);
  end
  wire m_act = is_mst_q && (st_q == PAL_ADDR || st_q == PAL_DATA);
  wire s_act = slave_hit_q && st_q == PAL_DATA;
  // Lane drivers; reset leaves every enable low
  assign bus.dev_ad_oe = (m_act && (st_q == PAL_ADDR || write_q)) ||
    (s_act && !slv_wr_q);
  assign bus.dev_ad_o = s_act ? rd_q : ad_q;
  assign bus.dev_cbe_oe = m_act;
  assign bus.dev_cbe_o = (st_q == PAL_ADDR) ?
    (write_q ? CMD_MEM_WRITE : CMD_MEM_READ) : be_q;
  assign bus.dev_frame_oe = m_act || (is_mst_q && hold_hi_q);
  assign bus.dev_frame_n_o = !(st_q == PAL_ADDR);
  assign bus.dev_irdy_oe = m_act || (is_mst_q && hold_hi_q);
  assign bus.dev_irdy_n_o = !(is_mst_q && st_q == PAL_DATA);
  assign bus.dev_trdy_oe = s_act || (slave_hit_q && hold_hi_q);
  assign bus.dev_trdy_n_o = !(s_act && !(slv_wr_q && buf_full));
endmodule // pal_dev_end
`default_nettype wire

// ==== rtl/pal_hst_end.sv ====
// Host end: issues single-word target transfers and serves master data
`timescale 1ns/100ps
`default_nettype none
module pal_hst_end
  import pal_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  pal_bus_if.hst bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [AD_W-1:0] req_addr,
  input wire logic [AD_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [AD_W-1:0] rsp_data,
  input wire logic [AD_W-1:0] mem_rdata,
  output logic mem_wr_valid,
  output logic [AD_W-1:0] mem_wr_data
);
  import pal_pkg::*;
  pal_state_t st_q, st_d;
  logic mst_q, wr_q, tgt_q, twr_q;
  logic [AD_W-1:0] ad_q;
  wire xfer = !bus.irdy_n && !bus.trdy_n;
  wire start = st_q == PAL_IDLE && bus.frame_n && !bus.hst_gnt_n && req_valid;
  wire seen = st_q == PAL_IDLE && !bus.frame_n && !start;
  assign req_ready = start;
  always_comb begin
    st_d = st_q;
    case (st_q)
      PAL_IDLE: if (start) st_d = PAL_ADDR; else if (seen) st_d = PAL_DATA;
      PAL_ADDR: st_d = PAL_DATA;
      PAL_DATA: if (xfer) st_d = PAL_TURN;
      PAL_TURN: st_d = PAL_IDLE;
      default: st_d = PAL_IDLE;
    endcase
  end
  // Sequence, response and memory-side capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= PAL_IDLE;
      mst_q <= 1'b0;
      wr_q <= 1'b0;
      tgt_q <= 1'b0;
      twr_q <= 1'b0;
      ad_q <= AD_RESET;
      rsp_valid <= 1'b0;
      rsp_data <= AD_RESET;
      mem_wr_valid <= 1'b0;
      mem_wr_data <= AD_RESET;
    end else begin
      st_q <= st_d;
      rsp_valid <= mst_q && st_q == PAL_DATA && xfer;
      mem_wr_valid <= tgt_q && twr_q && st_q == PAL_DATA && xfer;
      if (start) begin
        mst_q <= 1'b1;
        wr_q <= req_write;
        ad_q <= req_addr;
      end else if (seen) begin
        tgt_q <= 1'b1;
        twr_q <= bus.cbe[0];
        ad_q <= mem_rdata;
      end
      if (st_q == PAL_ADDR && wr_q) ad_q <= req_wdata;
      if (mst_q && st_q == PAL_DATA && xfer && !wr_q) rsp_data <= bus.ad;
      if (tgt_q && st_q == PAL_DATA && xfer) mem_wr_data <= bus.ad;
      if (st_q == PAL_TURN) begin
        mst_q <= 1'b0;
        tgt_q <= 1'b0;
      end
    end
  end
  wire m_act = mst_q && (st_q == PAL_ADDR || st_q == PAL_DATA);
  wire t_act = tgt_q && st_q == PAL_DATA;
  // Lane drivers for both roles
  assign bus.hst_ad_oe = (m_act && (st_q == PAL_ADDR || wr_q)) || (t_act && !twr_q);
  assign bus.hst_ad_o = ad_q;
  assign bus.hst_cbe_oe = m_act;
  assign bus.hst_cbe_o = st_q == PAL_ADDR ? (wr_q ? CMD_MEM_WRITE : CMD_MEM_READ) : BE_ALL;
  assign bus.hst_frame_oe = m_act;
  assign bus.hst_frame_n_o = !(st_q == PAL_ADDR);
  assign bus.hst_irdy_oe = m_act;
  assign bus.hst_irdy_n_o = !(mst_q && st_q == PAL_DATA);
  assign bus.hst_trdy_oe = t_act;
  assign bus.hst_trdy_n_o = !t_act;
endmodule // pal_hst_end
`default_nettype wire

// ==== bench/pal_lanes_sva.sv ====
// Checker on the shared lanes between the two lane ends
`timescale 1ns/100ps
`default_nettype none
module pal_lanes_sva
  import pal_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [AD_W-1:0] ad,
  input wire logic [BE_W-1:0] cbe,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic dev_ad_oe,
  input wire logic hst_ad_oe,
  input wire logic dev_cbe_oe,
  input wire logic dev_frame_oe,
  input wire logic dev_frame_n_o,
  input wire logic dev_irdy_oe,
  input wire logic dev_irdy_n_o,
  input wire logic dev_trdy_oe,
  input wire logic dev_trdy_n_o,
  input wire logic hst_frame_oe
);
  import pal_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Host address phase aimed at the device window
  wire logic hit = hst_frame_oe && !frame_n && ad[31:8] == BAR_DEFAULT[31:8];
  property p_quiet;
    disable iff (1'b0) !arst_n |-> !dev_ad_oe && !dev_cbe_oe && !dev_frame_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("lanes driven in reset");
  property p_lsb;
    dev_frame_oe && $fell(frame_n) |-> ad[1:0] == AD_LINEAR_BURST;
  endproperty
  a_lsb: assert property (p_lsb) else $error("low address bits set");
  property p_data;
    $fell(frame_n) |=> !irdy_n;
  endproperty
  a_data: assert property (p_data) else $error("no data phase");
  property p_one;
    !(dev_ad_oe && hst_ad_oe);
  endproperty
  a_one: assert property (p_one) else $error("two lane drivers");
  property p_hold;
    !irdy_n && trdy_n && hst_ad_oe |=> $stable(ad) && $stable(cbe);
  endproperty
  a_hold: assert property (p_hold) else $error("lanes moved in wait");
  property p_frm;
    $fell(dev_frame_oe) |-> $past(dev_frame_n_o);
  endproperty
  a_frm: assert property (p_frm) else $error("frame not high");
  property p_ird;
    $fell(dev_irdy_oe) |-> $past(dev_irdy_n_o);
  endproperty
  a_ird: assert property (p_ird) else $error("irdy not high");
  property p_trd;
    $fell(dev_trdy_oe) |-> $past(dev_trdy_n_o);
  endproperty
  a_trd: assert property (p_trd) else $error("trdy not high");
  property p_swr;
    $fell(frame_n) && hit && cbe == CMD_MEM_WRITE |-> ##[1:40] dev_trdy_oe && !trdy_n;
  endproperty
  a_swr: assert property (p_swr) else $error("write not claimed");
  property p_srd;
    $fell(frame_n) && hit && cbe == CMD_MEM_READ |-> ##[1:8] dev_ad_oe && !trdy_n;
  endproperty
  a_srd: assert property (p_srd) else $error("read not served");
  property p_mwr;
    dev_frame_oe && $fell(frame_n) && cbe == CMD_MEM_WRITE |=> dev_ad_oe;
  endproperty
  a_mwr: assert property (p_mwr) else $error("master data absent");
  c_swr: cover property ($fell(frame_n) && hit && cbe == CMD_MEM_WRITE);
  c_srd: cover property ($fell(frame_n) && hit && cbe == CMD_MEM_READ);
  c_mst: cover property (dev_frame_oe && $fell(frame_n));
endmodule // pal_lanes_sva
`default_nettype wire

// ==== bench/pci_address_data_lanes_test.sv ====
// Bench joining the device and host lane ends over one bus
`timescale 1ns/100ps
`default_nettype none
module pci_address_data_lanes_test;
  import pal_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, byte_swap_enable = 1'b0, slv_wr_ready = 1'b0;
  logic mst_req_valid = 1'b0, mst_write = 1'b0, mst_fifo = 1'b0, req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [AD_W-1:0] mst_addr = AD_RESET, mst_wdata = AD_RESET, slv_rd_data = AD_RESET;
  logic [AD_W-1:0] req_addr = AD_RESET, req_wdata = AD_RESET, mem_rdata = AD_RESET;
  logic [BE_W-1:0] mst_be_n = BE_ALL;
  logic mst_req_ready, mst_rd_valid, slv_wr_valid, req_ready, rsp_valid, mem_wr_valid;
  logic [AD_W-1:0] mst_rd_data, slv_wr_data, rsp_data, mem_wr_data;
  logic [BE_W-1:0] slv_wr_be_n;
  int n_fail = 0, check_count = 0, cyc = 0;
  pal_bus_if bus ();
  pal_dev_end #(.BAR(BAR_DEFAULT)) i_pal_dev_end (.clk(clk), .arst_n(arst_n), .bus(bus),
    .byte_swap_enable(byte_swap_enable), .mst_req_valid(mst_req_valid),
    .mst_req_ready(mst_req_ready), .mst_write(mst_write), .mst_addr(mst_addr),
    .mst_wdata(mst_wdata), .mst_be_n(mst_be_n), .mst_fifo(mst_fifo),
    .mst_rd_valid(mst_rd_valid), .mst_rd_data(mst_rd_data), .slv_wr_valid(slv_wr_valid),
    .slv_wr_ready(slv_wr_ready), .slv_wr_data(slv_wr_data), .slv_wr_be_n(slv_wr_be_n),
    .slv_rd_data(slv_rd_data));
  pal_hst_end i_pal_hst_end (.clk(clk), .arst_n(arst_n), .bus(bus), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .mem_rdata(mem_rdata), .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data));
  pal_lanes_sva i_pal_lanes_sva (.clk(clk), .arst_n(arst_n), .ad(bus.ad), .cbe(bus.cbe),
    .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .trdy_n(bus.trdy_n),
    .dev_ad_oe(bus.dev_ad_oe), .hst_ad_oe(bus.hst_ad_oe), .dev_cbe_oe(bus.dev_cbe_oe),
    .dev_frame_oe(bus.dev_frame_oe), .dev_frame_n_o(bus.dev_frame_n_o),
    .dev_irdy_oe(bus.dev_irdy_oe), .dev_irdy_n_o(bus.dev_irdy_n_o),
    .dev_trdy_oe(bus.dev_trdy_oe), .dev_trdy_n_o(bus.dev_trdy_n_o),
    .hst_frame_oe(bus.hst_frame_oe));
  // 8 ns bus clock
  always #4 clk = ~clk;
  task automatic chk(input logic [AD_W-1:0] got, input logic [AD_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Host request; data held two edges so the data phase still sees it
  task automatic hreq(input logic w, input logic [AD_W-1:0] a, input logic [AD_W-1:0] d);
    @(posedge clk);
    bus.hst_gnt_n <= 1'b0;
    bus.dev_gnt_n <= 1'b1;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    for (int k = 0; k < 40 && !req_ready; k++) @(posedge clk);
    req_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic mreq(input logic w, input logic [AD_W-1:0] a, input logic [AD_W-1:0] d);
    @(posedge clk);
    bus.dev_gnt_n <= 1'b0;
    bus.hst_gnt_n <= 1'b1;
    mst_req_valid <= 1'b1;
    mst_write <= w;
    mst_addr <= a;
    mst_wdata <= d;
    mst_fifo <= w;
    for (int k = 0; k < 40 && !mst_req_ready; k++) @(posedge clk);
    mst_req_valid <= 1'b0;
  endtask
  // Wait for a one-cycle result pulse; look first in the current cycle,
  // since the pulse may already stand when the request task returns
  task automatic await(input int sel);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 20 && !hit; k++) begin
      #1;
      hit = sel == 0 ? rsp_valid : (sel == 1 ? mem_wr_valid : mst_rd_valid);
      if (!hit) @(posedge clk);
    end
    chk({31'h0, hit}, 32'h1);
  endtask
  // Three writes into a stalled two-entry buffer, then drain
  task automatic t_host_write;
    logic [AD_W-1:0] w [3];
    int n;
    w = '{32'hA5C3_0F1E, 32'h0000_0001, 32'hFFFF_FFFF};
    n = 0;
    for (int i = 0; i < 3; i++) hreq(1'b1, BAR_DEFAULT + 32'(4 * i), w[i]);
    repeat (6) @(posedge clk);
    chk({31'h0, bus.trdy_n}, 32'h1);
    slv_wr_ready <= 1'b1;
    for (int k = 0; k < 30 && n < 3; k++) begin
      @(posedge clk);
      if (slv_wr_valid) begin
        chk(slv_wr_data, w[n]);
        chk({28'h0, slv_wr_be_n}, {28'h0, BE_ALL});
        n++;
      end
    end
    chk(32'(n), 32'h3);
    $display("test host_write done");
  endtask
  task automatic t_host_read;
    @(posedge clk);
    slv_rd_data <= 32'h1357_9BDF;
    hreq(1'b0, BAR_DEFAULT + 32'h0000_0024, AD_RESET);
    await(0);
    chk(rsp_data, 32'h1357_9BDF);
    $display("test host_read done");
  endtask
  // Master write swaps only FIFO data; plain read is never swapped
  task automatic t_dev_master(input logic s);
    @(posedge clk);
    byte_swap_enable <= s;
    mem_rdata <= 32'h0102_0304;
    mreq(1'b1, 32'h0000_2003, 32'h1122_3344);
    await(1);
    chk(mem_wr_data, s ? 32'h4433_2211 : 32'h1122_3344);
    mreq(1'b0, 32'h0000_3000, AD_RESET);
    await(2);
    chk(mst_rd_data, 32'h0102_0304);
    $display("test dev_master done");
  endtask
  initial begin
    bus.dev_gnt_n = 1'b1;
    bus.hst_gnt_n = 1'b1;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_host_write();
    t_host_read();
    t_dev_master(1'b0);
    t_dev_master(1'b1);
    tally_and_finish();
  end
  // Hang guard; the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
endmodule // pci_address_data_lanes_test
`default_nettype wire
